// >>> ecp_host.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Input qualifier: two-flop synchroniser then a stability filter.
// ------------------------------------------------------------------------
module ecp_qual #(
  parameter logic INIT = 1'b1
) (
  input wire logic ref_clk, // Core clock.
  input wire logic rst_b,   // Asynchronous reset, active low.
  input wire logic din,     // Raw pin level.
  output logic sync,        // Synchronised level, not filtered.
  output logic q            // Qualified level.
);
  import ecp_pkg::*;

  ecp_qual_s r;
  ecp_qual_s next_r;

  // A change is accepted only once the synced level has differed from
  // the qualified one for the full interval; any bounce restarts it.
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
    if (r.s2 == r.q) begin
      next_r.cnt = QUAL_CNT_RST;
    end else if (r.cnt == QUAL_LAST) begin
      next_r.q = r.s2;
      next_r.cnt = QUAL_CNT_RST;
    end else begin
      next_r.cnt = r.cnt + 5'h01;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{s1: INIT, s2: INIT, q: INIT, cnt: QUAL_CNT_RST};
    end else begin
      r <= next_r;
    end
  end

  assign sync = r.s2;
  assign q = r.q;

  a_qual_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(r.q) |-> $past(r.cnt) == QUAL_LAST && $past(r.s2) == r.q)
    else $error("qualified level changed before the interval");
endmodule

// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
module ecp_host (
  input wire logic ref_clk,              // 200 MHz core clock.
  input wire logic rst_b,                // Asynchronous reset, active low.
  input wire logic mode_ecp,             // 1 push-pull, 0 open-collector.
  input wire logic dir_rev,              // Requested direction, 1 reverse.
  input wire logic tx_valid,             // Outgoing byte waiting.
  input wire logic [7:0] tx_data,        // Outgoing byte.
  input wire logic tx_cmd,               // Flag, 1 data, 0 command.
  output logic tx_ready,                 // Byte taken, one-cycle pulse.
  input wire logic rx_room,              // Receive buffer has room.
  input wire logic tc_seen,              // Terminal count received.
  output logic rx_valid,                 // Byte received, one-cycle pulse.
  output logic [7:0] rx_data,            // Received byte.
  output logic periph_req,               // Reverse requested, active high.
  output logic rev_active,               // Link in the reverse direction.
  input wire ecp_pkg::ecp_pin_in_s pin_i, // Pin levels in.
  output ecp_pkg::ecp_pin_out_s pin_o     // Pin drive out.
);
  import ecp_pkg::*;

  ecp_top_s r;
  ecp_top_s next_r;
  logic busy_q;
  logic nack_q;
  logic nfault_s;

  // ----------------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------------
  // BUSY idles low, nAck and nFault idle high.
  ecp_qual #(.INIT(1'b0)) u_busy (.ref_clk(ref_clk), .rst_b(rst_b),
    .din(pin_i.busy), .sync(), .q(busy_q));
  ecp_qual #(.INIT(1'b1)) u_nack (.ref_clk(ref_clk), .rst_b(rst_b),
    .din(pin_i.nack), .sync(), .q(nack_q));
  // The fault request is level only, so it is passed on after the sync.
  ecp_qual #(.INIT(1'b1)) u_nflt (.ref_clk(ref_clk), .rst_b(rst_b),
    .din(pin_i.nfault), .sync(nfault_s), .q());

  // ----------------------------------------------------------------------
  // Handshake engine
  // ----------------------------------------------------------------------
  // Direction changes are taken only from the two idle states so a byte
  // in flight is never cut.
  always_comb begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    next_r.tx_ready = 1'b0;
    case (r.st)
      ST_FIDLE: begin
        next_r.stb_v = 1'b1;
        if (dir_rev && !busy_q) begin
          next_r.st = ST_RIDLE;
          next_r.afd_v = 1'b0;
        end else if (tx_valid && !busy_q) begin
          next_r.pins.pd = tx_data;
          next_r.afd_v = tx_cmd;
          next_r.tx_ready = 1'b1;
          next_r.st = ST_FSETUP;
        end
      end
      ST_FSETUP: begin
        next_r.stb_v = 1'b0;
        next_r.st = ST_FSTB;
      end
      ST_FSTB: begin
        if (busy_q) begin
          next_r.stb_v = 1'b1;
          next_r.st = ST_FREL;
        end
      end
      ST_FREL: begin
        if (!busy_q) begin
          next_r.st = ST_FIDLE;
        end
      end
      ST_RIDLE: begin
        next_r.afd_v = 1'b0;
        if (!dir_rev && nack_q) begin
          next_r.st = ST_RTURN;
        end else if (!nack_q && rx_room && !tc_seen) begin
          next_r.rx_data = pin_i.pd;
          next_r.afd_v = 1'b1;
          next_r.st = ST_RACK;
        end
      end
      ST_RACK: begin
        if (nack_q) begin
          next_r.rx_valid = 1'b1;
          next_r.afd_v = 1'b0;
          next_r.st = ST_RIDLE;
        end
      end
      ST_RTURN: begin
        next_r.afd_v = 1'b1;
        next_r.st = ST_FIDLE;
      end
      default: begin
        next_r = TOP_RST;
      end
    endcase
    // Output drivers. In open-collector mode a high is a released pin,
    // so the wire level equals the logical value in both modes and a
    // mode flip never moves the line.
    next_r.pins.nstb = mode_ecp ? next_r.stb_v : 1'b0;
    next_r.pins.nstb_oe = mode_ecp | ~next_r.stb_v;
    next_r.pins.nafd = mode_ecp ? next_r.afd_v : 1'b0;
    next_r.pins.nafd_oe = mode_ecp | ~next_r.afd_v;
    next_r.pins.pd_oe = (next_r.st & (ST_RIDLE | ST_RACK)) == 7'h00;
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= TOP_RST;
    end else begin
      r <= next_r;
    end
  end

  assign pin_o = r.pins;
  assign tx_ready = r.tx_ready;
  assign rx_valid = r.rx_valid;
  assign rx_data = r.rx_data;
  assign periph_req = ~nfault_s;
  assign rev_active = (r.st == ST_RIDLE) || (r.st == ST_RACK);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  logic lvl_stb;
  logic lvl_afd;
  assign lvl_stb = pin_o.nstb_oe ? pin_o.nstb : 1'b1;
  assign lvl_afd = pin_o.nafd_oe ? pin_o.nafd : 1'b1;

  sequence s_byte_offered;
    r.st == ST_RIDLE && !nack_q && rx_room && !tc_seen;
  endsequence
  sequence s_ack_high;
    r.st == ST_RACK && pin_o.nafd == 1'b1;
  endsequence

  a_rev_entry: assert property ($rose(r.st == ST_RACK) |->
    $past(r.st) == ST_RIDLE)
    else $error("reverse transfer entered from wrong state");
  a_ack_raise: assert property (s_byte_offered ##0 mode_ecp |=>
    s_ack_high)
    else $error("HostAck not raised for offered byte");
  a_rev_done: assert property (r.st == ST_RACK && nack_q |=>
    rx_valid && !r.afd_v && rx_data == $past(r.rx_data))
    else $error("reverse byte not completed");
  a_rev_stall: assert property (r.st == ST_RIDLE &&
    (!rx_room || tc_seen) |=> lvl_afd == 1'b0)
    else $error("HostAck left low stall");
  a_strobe_rel: assert property ($rose(lvl_stb) |-> $past(busy_q))
    else $error("strobe released before BUSY high");
  a_data_stable: assert property (lvl_stb == 1'b0 |->
    $stable(pin_o.pd) && $stable(r.afd_v))
    else $error("data moved under strobe");
  a_data_change: assert property ($changed(pin_o.pd) && pin_o.pd_oe |->
    !$past(busy_q, 2))
    else $error("data changed while BUSY high");
  a_fwd_prompt: assert property (r.st == ST_FIDLE && !dir_rev &&
    tx_valid && !busy_q |=> tx_ready ##1 lvl_stb == 1'b0)
    else $error("strobe not launched promptly");
  a_oc_drive: assert property (!$past(mode_ecp) |->
    (!pin_o.nstb_oe || !pin_o.nstb) && (!pin_o.nafd_oe || !pin_o.nafd))
    else $error("control driven high in compatible mode");
  // The state must hold across the edge that applies the new mode, or a
  // normal handshake step would be mistaken for a driver glitch.
  a_no_glitch: assert property ($changed(mode_ecp) |=> $stable(r.st) |->
    $stable(lvl_stb) && $stable(lvl_afd))
    else $error("driver change moved the line");
endmodule

// >>> ecp_pkg.sv
package ecp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int QUAL_MIN_NS = 75;
  localparam int QUAL_MAX_NS = 130;
  // Least time rounds up to whole cycles of the 200 MHz clock.
  localparam int QUAL_CYC =
    (QUAL_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0] QUAL_LAST = 5'(QUAL_CYC - 1);
  localparam logic [4:0] QUAL_CNT_RST = 5'h00;

  // ----------------------------------------------------------------------
  // Handshake states
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_FIDLE  = 7'h01,
    ST_FSETUP = 7'h02,
    ST_FSTB   = 7'h04,
    ST_FREL   = 7'h08,
    ST_RIDLE  = 7'h10,
    ST_RACK   = 7'h20,
    ST_RTURN  = 7'h40
  } ecp_state_e;

  // ----------------------------------------------------------------------
  // Pin carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pd;
    logic busy;
    logic nack;
    logic nfault;
  } ecp_pin_in_s;

  typedef struct packed {
    logic [7:0] pd;
    logic pd_oe;
    logic nstb;
    logic nstb_oe;
    logic nafd;
    logic nafd_oe;
  } ecp_pin_out_s;

  typedef struct packed {
    ecp_state_e st;
    logic stb_v;
    logic afd_v;
    logic [7:0] rx_data;
    logic rx_valid;
    logic tx_ready;
    ecp_pin_out_s pins;
  } ecp_top_s;

  localparam ecp_pin_out_s PINS_RST = '{pd: 8'h00, pd_oe: 1'b0,
    nstb: 1'b1, nstb_oe: 1'b0, nafd: 1'b1, nafd_oe: 1'b0};
  localparam ecp_top_s TOP_RST = '{st: ST_FIDLE, stb_v: 1'b1,
    afd_v: 1'b1, rx_data: 8'h00, rx_valid: 1'b0, tx_ready: 1'b0,
    pins: PINS_RST};

  typedef struct packed {
    logic s1;
    logic s2;
    logic q;
    logic [4:0] cnt;
  } ecp_qual_s;

endpackage

// >>> ecp_periph.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Peripheral at the far end of the cable
// ----------------------------------------------------------------------
module ecp_periph (
  input wire logic ref_clk,        // Clock that paces the model.
  input wire logic nstb_w,         // Strobe wire level.
  input wire logic nafd_w,         // Auto-feed wire level.
  input wire logic [7:0] pd_w,     // Data wire level.
  input wire logic [4:0] lag,      // Answer delay in cycles.
  input wire logic snd_go,         // Send one reverse byte.
  input wire logic [7:0] snd_byte, // Byte to send.
  output logic busy,               // Busy line.
  output logic nack,               // Ack line, active low.
  output logic [7:0] pd_drv,       // Data the model puts on the lines.
  output logic [8:0] got           // Last flag and byte taken.
);
  // Forward: take the byte at the strobe, answer with busy.
  initial begin
    busy = 1'b0;
    got = 9'h000;
    forever begin
      @(posedge ref_clk iff !nstb_w);
      got = {nafd_w, pd_w};
      repeat (lag) @(posedge ref_clk);
      #1 busy = 1'b1;
      @(posedge ref_clk iff nstb_w);
      repeat (lag) @(posedge ref_clk);
      #1 busy = 1'b0;
    end
  end

  // Reverse: data settles before the clock falls. Released data shows
  // the inverse, so a late sample by the host cannot match by chance.
  initial begin
    nack = 1'b1;
    pd_drv = 8'h00;
    forever begin
      @(posedge ref_clk iff snd_go);
      #1 pd_drv = snd_byte;
      repeat (lag) @(posedge ref_clk);
      #1 nack = 1'b0;
      @(posedge ref_clk iff nafd_w);
      repeat (lag) @(posedge ref_clk);
      #1 nack = 1'b1;
      @(posedge ref_clk iff !nafd_w);
      #1 pd_drv = ~snd_byte;
    end
  end
endmodule

// >>> ecp_host_test.sv
`timescale 1ns/1ps

module ecp_host_test;
  import ecp_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, mode_ecp = 1'b1, dir_rev = 1'b0;
  logic tx_valid = 1'b0, tx_cmd = 1'b0, rx_room = 1'b1, tc_seen = 1'b0;
  logic nfault = 1'b1, snd_go = 1'b0;
  logic [7:0] tx_data = 8'h00, snd_byte = 8'h00;
  logic [4:0] lag = 5'h00;
  logic tx_ready, rx_valid, periph_req, rev_active, busy, nack;
  logic nstb_w, nafd_w;
  logic [7:0] rx_data, pd_drv, pd_w;
  logic [8:0] got;
  ecp_pin_in_s pin_i;
  ecp_pin_out_s pin_o;
  int err_count = 0, n_compared = 0;

  // Released control lines float high on their pull-ups.
  assign nstb_w = pin_o.nstb_oe ? pin_o.nstb : 1'b1;
  assign nafd_w = pin_o.nafd_oe ? pin_o.nafd : 1'b1;
  assign pd_w = pin_o.pd_oe ? pin_o.pd : pd_drv;
  assign pin_i = '{pd: pd_w, busy: busy, nack: nack, nfault: nfault};

  ecp_host uut (.ref_clk(ref_clk), .rst_b(rst_b), .mode_ecp(mode_ecp),
    .dir_rev(dir_rev), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_cmd(tx_cmd), .tx_ready(tx_ready), .rx_room(rx_room),
    .tc_seen(tc_seen), .rx_valid(rx_valid), .rx_data(rx_data),
    .periph_req(periph_req), .rev_active(rev_active), .pin_i(pin_i),
    .pin_o(pin_o));

  ecp_periph peer (.ref_clk(ref_clk), .nstb_w(nstb_w), .nafd_w(nafd_w),
    .pd_w(pd_w), .lag(lag), .snd_go(snd_go), .snd_byte(snd_byte),
    .busy(busy), .nack(nack), .pd_drv(pd_drv), .got(got));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Inputs move 1 ns after the edge, clear of the sampling instant.
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // One forward byte; lo is the least wait for the take, more keeps the
  // next byte waiting so the following take must follow promptly.
  task automatic t_fwd(input logic [7:0] b, input logic c, input int lg,
                       input int lo, input logic more);
    int n;
    lag = 5'(lg);
    tx_data = b;
    tx_cmd = c;
    tx_valid = 1'b1;
    for (n = 0; n < 60 && tx_ready !== 1'b1; n++) step(1);
    chk("take delay", 9'h001, 9'(n >= lo && n <= 40));
    tx_valid = more;
    for (n = 0; n < 10 && nstb_w !== 1'b0; n++) step(1);
    chk("strobe low", 9'h000, 9'(n >= 10));
    chk("fwd lines", {c, b}, {nafd_w, pd_w});
    for (n = 0; n < 60 && busy !== 1'b1; n++) step(1);
    chk("busy wait", 9'h000, 9'(n >= 60));
    for (n = 0; n < 60 && nstb_w !== 1'b1; n++) step(1);
    chk("strobe hold", 9'h001, 9'(n >= QUAL_CYC && n <= 36));
    chk("drive kind", mode_ecp ? 9'h003 : 9'h000,
        {7'h00, pin_o.nstb, pin_o.nstb_oe});
    chk("peer got", {c, b}, got);
    for (n = 0; n < 60 && busy !== 1'b0; n++) step(1);
    chk("busy end", 9'h000, 9'(n >= 60));
  endtask

  // One reverse byte; st 1 stalls on a full buffer, 2 on terminal count.
  task automatic t_rev(input logic [7:0] b, input int lg, input int st);
    int n;
    lag = 5'(lg);
    snd_byte = b;
    rx_room = (st != 1);
    tc_seen = (st == 2);
    // Hold the send request until the model answers; it may still be
    // closing the previous byte when this task starts.
    snd_go = 1'b1;
    for (n = 0; n < 60 && nack !== 1'b0; n++) step(1);
    snd_go = 1'b0;
    chk("nack wait", 9'h000, 9'(n >= 60));
    for (n = 0; n < 60 && nafd_w !== 1'b1; n++) step(1);
    if (st != 0) begin
      chk("stall", 9'h000, {8'h00, nafd_w});
      rx_room = 1'b1;
      tc_seen = 1'b0;
      for (n = 0; n < 10 && nafd_w !== 1'b1; n++) step(1);
      chk("stall end", 9'h000, 9'(n >= 10));
    end else begin
      chk("ack delay", 9'h001, 9'(n >= QUAL_CYC && n <= 40));
    end
    for (n = 0; n < 80 && rx_valid !== 1'b1; n++) step(1);
    chk("rx wait", 9'h000, 9'(n >= 80));
    chk("rx byte", {1'b0, b}, {1'b0, rx_data});
    chk("ack low", 9'h000, {8'h00, nafd_w});
  endtask

  task automatic t_dir(input logic rev);
    int n;
    dir_rev = rev;
    for (n = 0; n < 60 && rev_active !== rev; n++) step(1);
    chk("dir wait", 9'h000, 9'(n >= 60));
    step(2);
    chk("idle ack", {8'h00, !rev}, {8'h00, nafd_w});
  endtask

  task automatic t_req;
    nfault = 1'b0;
    step(3);
    chk("req on", 9'h001, {8'h00, periph_req});
    nfault = 1'b1;
    step(3);
    chk("req off", 9'h000, {8'h00, periph_req});
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Whole run needs under a thousand cycles; twenty times that is a hang.
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    chk("reset pins", 9'h003, {4'h0, pin_o.nafd_oe, pin_o.nstb_oe,
        rev_active, pin_o.nstb, pin_o.nafd});
    #1 rst_b = 1'b1;
    step(1);
    t_fwd(8'hA5, 1'b1, 0, 0, 1'b1);
    t_fwd(8'h00, 1'b0, 3, QUAL_CYC, 1'b0);
    mode_ecp = 1'b0;
    t_fwd(8'hFF, 1'b1, 1, QUAL_CYC, 1'b0);
    mode_ecp = 1'b1;
    t_req();
    t_dir(1'b1);
    t_rev(8'h5A, 0, 0);
    t_rev(8'hC3, 4, 1);
    t_rev(8'h81, 0, 2);
    t_dir(1'b0);
    t_fwd(8'h7E, 1'b0, 2, 0, 1'b0);
    wrap_up();
  end
endmodule
